/* common/pmeac_pkg.sv */
// Package of constants and types for the event latch and power sequencer.
package pmeac_pkg;

  // Register indices; the byte address of a register is four times its index.
  localparam logic [7:0] IDX_STATUS_ONE = 8'hF2;
  localparam logic [7:0] IDX_STATUS_SERIAL = 8'hF3;
  localparam logic [7:0] IDX_CONTROL_A = 8'hF4;
  localparam logic [7:0] IDX_CONTROL_B = 8'hF5;
  localparam logic [7:0] IDX_CONTROL_C = 8'hF6;
  localparam logic [7:0] IDX_ENABLE_ONE = 8'hF0;
  localparam logic [7:0] IDX_ENABLE_SERIAL = 8'hF1;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hE1;
  localparam logic [7:0] IDX_PIN_STATE = 8'hE2;

  // Bit positions inside the control registers.
  localparam int A_SLEEP_TEST = 7;
  localparam int A_FLASH_RST_EN = 6;
  localparam int A_KBD_WAKE = 4;
  localparam int A_MOUSE_WAKE = 3;
  localparam int A_POLICY_LO = 1;
  localparam int A_LOSS = 0;
  localparam int B_SOFT_RESET = 7;
  localparam int B_EXTRA_LO = 5;
  localparam int B_BASE_LO = 3;
  localparam int B_DEBOUNCE_EN = 2;
  localparam int C_SLEEP_SELECT = 7;
  localparam int C_ON_DELAY_EN = 4;
  localparam int C_DEBOUNCE_BYPASS = 1;

  // Writable bits of the registers and reset values of the three control registers.
  localparam logic [7:0] MASK_ONE = 8'h7F;
  localparam logic [7:0] MASK_SERIAL = 8'h3F;
  localparam logic [7:0] MASK_A = 8'hFF;
  localparam logic [7:0] MASK_B = 8'hFC;
  localparam logic [7:0] MASK_C = 8'h93;
  localparam logic [7:0] MASK_IRQ = 8'h0F;
  localparam logic [7:0] RESET_A = 8'h07;
  localparam logic [7:0] RESET_B = 8'h1C;
  localparam logic [7:0] RESET_C = 8'h00;

  // Power restore policy codes.
  localparam logic [1:0] POL_KEEP = 2'h0;
  localparam logic [1:0] POL_BYPASS = 2'h1;
  localparam logic [1:0] POL_ON = 2'h2;

  // Timing, each figure in its own unit and its cycle count derived.
  localparam int CLK_MHZ = 100;
  localparam int STEP_MS = 100;
  localparam int OFF_HOLD_S = 4;
  localparam int DEBOUNCE_US = 10;
  localparam int STEP_CYCLES_DEF = STEP_MS * 1000 * CLK_MHZ;
  localparam int OFF_HOLD_CYCLES_DEF = OFF_HOLD_S * 1000000 * CLK_MHZ;
  localparam logic [9:0] DEBOUNCE_CYCLES = 10'(DEBOUNCE_US * CLK_MHZ);
  localparam logic [4:0] WAKE_PULSE_CYCLES = 5'h10;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Power-good sequencing states.
  typedef enum logic [1:0] {PG_OFF, PG_WAIT, PG_ON} pmeac_pg_e;

  // Event pulses from the seven units and the six serial ports.
  typedef struct packed {
    logic [6:0] one;
    logic [5:0] serial;
  } pmeac_events_s;

  // Pins from the power supply and chipset, asynchronous to aclk.
  typedef struct packed {
    logic main_supply_valid;
    logic bus_reset_in_n;
    logic supply_power_good_in;
    logic sleep_state_in_n;
    logic keyboard_wake_in;
    logic mouse_wake_in;
    logic power_restore_in;
  } pmeac_pins_s;

  // Pins toward the power supply and chipset.
  typedef struct packed {
    logic supply_on_output_n;
    logic wake_button_out_n;
    logic wake_event_out_n;
    logic power_good_out;
    logic kbc_sleep_state;
    logic bus_reset_out_n;
    logic flash_reset_out;
    logic pme_out_n;
  } pmeac_power_s;

endpackage

/* hw/pmeac_top.sv */
// Event latch, power sequencer and AXI4-Lite register slave.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps

// Behaviour
// R1 - Latch seven unit events into status one.
// R2 - Latch six serial port events, port six high.
// R3 - Writing one clears a status bit.
// R4 - Bits stay set; zero writes ignored; reserved zero.
// R5 - Enabled latched events drive the event output.
// R6 - Sleep test bit forces keyboard controller sleep.
// R7 - Flash time-out reset only when enabled.
// R8 - Keyboard wake drives wake pin when enabled.
// R9 - Mouse wake drives wake pin when enabled.
// R10 - Restore policy sets supply on after return.
// R11 - Standby loss flag set on arrival, cleared.
// R12 - Soft reset bit resets logic, self clears.
// R13 - Power good after base plus extra delay.
// R14 - De-bounce reset and supply good when enabled.
// R15 - Sleep select picks keyboard controller sleep source.
// R16 - Supply on follows sleep or waits hold.
// R17 - Bypass bit disables every de-bounce circuit.
module pmeac_top #(
  parameter int STEP_CYCLES = pmeac_pkg::STEP_CYCLES_DEF,
  parameter int OFF_HOLD_CYCLES = pmeac_pkg::OFF_HOLD_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pmeac_pkg::pmeac_events_s events,
  input wire logic flash_timeout,
  input wire pmeac_pkg::pmeac_pins_s pins_in,
  output pmeac_pkg::pmeac_power_s power_out,
  output logic irq
);
  import pmeac_pkg::*;

  typedef struct packed {
    logic aw_ok;
    logic [7:0] aw_idx;
    logic aw_bad;
    logic w_ok;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [6:0] status_one;
    logic [5:0] status_serial;
    logic [6:0] enable_one;
    logic [5:0] enable_serial;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic restore_prev;
    logic sleep_prev;
    logic [1:0] db_out;
    logic [1:0][9:0] db_cnt;
    pmeac_pg_e pg_state;
    logic [31:0] pg_cnt;
    logic [2:0] pg_units;
    logic supply_on;
    logic last_on;
    logic bypass_on;
    logic [31:0] off_cnt;
    logic [4:0] wake_cnt;
    pmeac_power_s pout;
    logic irq;
  } pmeac_state_s;

  pmeac_state_s st_ff;
  pmeac_state_s nxt_st;

  // Decodes a byte address; only word-aligned addresses below 1 KiB map.
  function automatic logic idx_mapped(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    idx_mapped = (addr[11:10] == 2'h0) && (addr[1:0] == 2'h0) &&
      (idx == IDX_STATUS_ONE || idx == IDX_STATUS_SERIAL ||
       idx == IDX_CONTROL_A || idx == IDX_CONTROL_B ||
       idx == IDX_CONTROL_C || idx == IDX_ENABLE_ONE ||
       idx == IDX_ENABLE_SERIAL || idx == IDX_IRQ_STATUS ||
       idx == IDX_IRQ_MASK || idx == IDX_PIN_STATE);
  endfunction

  // Read view of one register; reserved bits return zero.
  function automatic logic [7:0] read_reg(input logic [7:0] idx,
                                          input pmeac_state_s s);
    read_reg = 8'h00;
    case (idx)
      IDX_STATUS_ONE: read_reg = {1'b0, s.status_one}; // R4
      IDX_STATUS_SERIAL: read_reg = {2'h0, s.status_serial}; // R4
      IDX_CONTROL_A: read_reg = s.ctrl_a;
      IDX_CONTROL_B: read_reg = s.ctrl_b & MASK_B;
      IDX_CONTROL_C: read_reg = s.ctrl_c & MASK_C;
      IDX_ENABLE_ONE: read_reg = {1'b0, s.enable_one};
      IDX_ENABLE_SERIAL: read_reg = {2'h0, s.enable_serial};
      IDX_IRQ_STATUS: read_reg = {4'h0, s.irq_status};
      IDX_IRQ_MASK: read_reg = {4'h0, s.irq_mask};
      IDX_PIN_STATE: read_reg = {s.pout.power_good_out, s.supply_on,
        s.pout.kbc_sleep_state, s.db_out, s.bypass_on, s.last_on,
        s.sync2[6]};
      default: read_reg = 8'h00;
    endcase
  endfunction

  logic wr_fire;
  logic [7:0] wr_ones;
  logic rd_fire;
  logic soft_now;
  logic [1:0] db_raw;
  logic db_off;
  logic main_ok;
  logic sleep_awake;
  logic restore_edge;
  logic want_on;
  logic on_allowed;
  logic [2:0] extra_units;
  logic [2:0] total_units;

  // Ready terms depend only on registered state, so they never loop back.
  assign s_axi_awready = !st_ff.aw_ok && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_ok && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = {24'h000000, st_ff.rdata};
  assign power_out = st_ff.pout;
  assign irq = st_ff.irq;

  // Shared decode of the write that completes this cycle.
  assign wr_fire = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid &&
    !st_ff.aw_bad;
  assign wr_ones = st_ff.w_lane ? st_ff.w_data : 8'h00;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign soft_now = st_ff.ctrl_b[B_SOFT_RESET];
  assign db_raw = {st_ff.sync2[5], st_ff.sync2[4]}; // Reset, supply good.
  assign db_off = st_ff.ctrl_c[C_DEBOUNCE_BYPASS] ||
    !st_ff.ctrl_b[B_DEBOUNCE_EN];
  assign main_ok = st_ff.sync2[6];
  assign sleep_awake = st_ff.sync2[3];
  assign restore_edge = st_ff.sync2[0] && !st_ff.restore_prev;
  assign want_on = sleep_awake || st_ff.bypass_on;
  assign on_allowed = !st_ff.ctrl_c[C_ON_DELAY_EN] ||
    (st_ff.off_cnt == 32'h00000000);

  // Extra power-good delay is 0, 1, 2 or 4 steps; base is 1 to 4 steps.
  always_comb begin
    case (st_ff.ctrl_b[B_EXTRA_LO +: 2])
      2'h0: extra_units = 3'h0;
      2'h1: extra_units = 3'h1;
      2'h2: extra_units = 3'h2;
      default: extra_units = 3'h4;
    endcase
    total_units = 3'(st_ff.ctrl_b[B_BASE_LO +: 2]) + 3'h1 + extra_units;
  end

  // Next state of the whole block.
  always_comb begin
    nxt_st = st_ff;
    // Bus slave: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.aw_idx = s_axi_awaddr[9:2];
      nxt_st.aw_bad = !idx_mapped(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.w_data = s_axi_wdata[7:0];
      nxt_st.w_lane = s_axi_wstrb[0];
    end
    if (st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid) begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = st_ff.aw_bad ? RESP_DECERR : RESP_OKAY;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = idx_mapped(s_axi_araddr) ?
        read_reg(s_axi_araddr[9:2], st_ff) : 8'h00;
      nxt_st.rresp = idx_mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // Plain register writes; a byte lane that is off writes nothing.
    if (wr_fire && st_ff.w_lane) begin
      case (st_ff.aw_idx)
        IDX_CONTROL_A: begin
          nxt_st.ctrl_a = (st_ff.w_data & ~(8'h01 << A_LOSS)) |
            (st_ff.ctrl_a & (8'h01 << A_LOSS));
        end
        IDX_CONTROL_B: nxt_st.ctrl_b = st_ff.w_data & MASK_B;
        IDX_CONTROL_C: nxt_st.ctrl_c = st_ff.w_data & MASK_C;
        IDX_ENABLE_ONE: nxt_st.enable_one = st_ff.w_data[6:0];
        IDX_ENABLE_SERIAL: nxt_st.enable_serial = st_ff.w_data[5:0];
        IDX_IRQ_MASK: nxt_st.irq_mask = st_ff.w_data[3:0];
        default: nxt_st.irq_mask = st_ff.irq_mask;
      endcase
    end
    // Event latches: a one clears, a zero keeps, and a new event wins.
    if (wr_fire && st_ff.aw_idx == IDX_STATUS_ONE) begin
      nxt_st.status_one = st_ff.status_one & ~wr_ones[6:0]; // R3
    end
    if (wr_fire && st_ff.aw_idx == IDX_STATUS_SERIAL) begin
      nxt_st.status_serial = st_ff.status_serial & ~wr_ones[5:0]; // R3
    end
    nxt_st.status_one = nxt_st.status_one | events.one; // R1
    nxt_st.status_serial = nxt_st.status_serial | events.serial; // R2
    // The loss flag is only cleared by software; it is set at power-up.
    if (wr_fire && st_ff.aw_idx == IDX_CONTROL_A && wr_ones[A_LOSS]) begin
      nxt_st.ctrl_a[A_LOSS] = 1'b0; // R11
    end
    // Two flip-flops on every pin before any logic looks at it.
    nxt_st.sync1 = pins_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.restore_prev = st_ff.sync2[0];
    nxt_st.sleep_prev = st_ff.sync2[3];
    // De-bounce: output follows raw input once stable for the window.
    for (int i = 0; i < 2; i++) begin
      if (db_off) begin
        nxt_st.db_out[i] = db_raw[i]; // R17
        nxt_st.db_cnt[i] = 10'h000;
      end else if (db_raw[i] == st_ff.db_out[i]) begin
        nxt_st.db_cnt[i] = 10'h000;
      end else if (st_ff.db_cnt[i] == DEBOUNCE_CYCLES - 10'h001) begin
        nxt_st.db_out[i] = db_raw[i]; // R14
        nxt_st.db_cnt[i] = 10'h000;
      end else begin
        nxt_st.db_cnt[i] = st_ff.db_cnt[i] + 10'h001;
      end
    end
    // Power-good sequencer; a drop of main supply ends it at once, a drop of supply good once it is de-bounced.
    case (st_ff.pg_state)
      PG_OFF: begin
        nxt_st.pg_cnt = 32'h00000000;
        nxt_st.pg_units = 3'h0;
        if (main_ok && st_ff.db_out[0]) begin
          nxt_st.pg_state = PG_WAIT;
        end
      end
      PG_WAIT: begin
        if (!(main_ok && st_ff.db_out[0])) begin
          nxt_st.pg_state = PG_OFF;
        end else if (st_ff.pg_cnt == 32'(STEP_CYCLES - 1)) begin
          nxt_st.pg_cnt = 32'h00000000;
          nxt_st.pg_units = st_ff.pg_units + 3'h1;
          if (st_ff.pg_units + 3'h1 == total_units) begin
            nxt_st.pg_state = PG_ON; // R13
          end
        end else begin
          nxt_st.pg_cnt = st_ff.pg_cnt + 32'h00000001;
        end
      end
      PG_ON: begin
        if (!(main_ok && st_ff.db_out[0])) begin
          nxt_st.pg_state = PG_OFF;
        end
      end
      default: nxt_st.pg_state = PG_OFF;
    endcase
    // Restore policy runs on the rising edge of mains return.
    if (restore_edge) begin
      case (st_ff.ctrl_a[A_POLICY_LO +: 2]) // R10
        POL_BYPASS: nxt_st.bypass_on = 1'b1;
        POL_ON: nxt_st.wake_cnt = WAKE_PULSE_CYCLES;
        POL_KEEP: begin
          if (st_ff.last_on) begin
            nxt_st.wake_cnt = WAKE_PULSE_CYCLES;
          end
        end
        default: nxt_st.bypass_on = 1'b0;
      endcase
    end else if (st_ff.wake_cnt != 5'h00) begin
      nxt_st.wake_cnt = st_ff.wake_cnt - 5'h01;
    end
    // Bypass ends on a falling sleep input, so a low level cannot undo it.
    if (st_ff.bypass_on && st_ff.sleep_prev && !st_ff.sync2[3] &&
        !restore_edge) begin
      nxt_st.bypass_on = 1'b0;
    end
    // Supply on: once on it stays on while want_on holds; turning on may wait for the hold.
    nxt_st.supply_on = want_on && (on_allowed || st_ff.supply_on); // R16
    if (st_ff.supply_on && !nxt_st.supply_on) begin
      nxt_st.off_cnt = 32'(OFF_HOLD_CYCLES);
    end else if (st_ff.off_cnt != 32'h00000000) begin
      nxt_st.off_cnt = st_ff.off_cnt - 32'h00000001;
    end
    // Last state is frozen while mains is away so restore can use it.
    if (st_ff.sync2[0]) begin
      nxt_st.last_on = st_ff.supply_on;
    end
    // Software reset of the sequencing logic; the bit clears afterwards.
    if (soft_now) begin
      nxt_st.ctrl_b[B_SOFT_RESET] = 1'b0; // R12
      nxt_st.pg_state = PG_OFF;
      nxt_st.pg_cnt = 32'h00000000;
      nxt_st.pg_units = 3'h0;
      nxt_st.db_cnt = '0;
      nxt_st.db_out = db_raw;
      nxt_st.bypass_on = 1'b0;
      nxt_st.off_cnt = 32'h00000000;
      nxt_st.wake_cnt = 5'h00;
    end
    // Output pins, all registered.
    nxt_st.pout.power_good_out = (nxt_st.pg_state == PG_ON);
    nxt_st.pout.supply_on_output_n = !nxt_st.supply_on;
    nxt_st.pout.wake_button_out_n = (nxt_st.wake_cnt == 5'h00);
    nxt_st.pout.wake_event_out_n =
      !((st_ff.ctrl_a[A_KBD_WAKE] && st_ff.sync2[2]) || // R8
        (st_ff.ctrl_a[A_MOUSE_WAKE] && st_ff.sync2[1])); // R9
    if (st_ff.ctrl_a[A_SLEEP_TEST]) begin
      nxt_st.pout.kbc_sleep_state = 1'b1; // R6
    end else if (st_ff.ctrl_c[C_SLEEP_SELECT]) begin
      nxt_st.pout.kbc_sleep_state = !sleep_awake; // R15
    end else begin
      nxt_st.pout.kbc_sleep_state = !main_ok; // R15
    end
    nxt_st.pout.bus_reset_out_n = st_ff.db_out[1]; // R14
    nxt_st.pout.flash_reset_out = st_ff.ctrl_a[A_FLASH_RST_EN] &&
      flash_timeout && st_ff.pout.power_good_out; // R7
    nxt_st.pout.pme_out_n = !(|({st_ff.status_one, st_ff.status_serial} &
      {st_ff.enable_one, st_ff.enable_serial})); // R5
    // Interrupt events; a read clears, but a same-cycle event still sets.
    if (rd_fire && s_axi_araddr[9:2] == IDX_IRQ_STATUS &&
        idx_mapped(s_axi_araddr)) begin
      nxt_st.irq_status = 4'h0;
    end
    nxt_st.irq_status = nxt_st.irq_status | {
      st_ff.supply_on != nxt_st.supply_on,
      st_ff.pout.power_good_out && !nxt_st.pout.power_good_out,
      !st_ff.pout.power_good_out && nxt_st.pout.power_good_out,
      st_ff.pout.pme_out_n && !nxt_st.pout.pme_out_n};
    nxt_st.irq = |(nxt_st.irq_status & st_ff.irq_mask);
  end

  // State register; the loss flag reads one after standby arrives.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.ctrl_a <= RESET_A; // R11
      st_ff.ctrl_b <= RESET_B;
      st_ff.ctrl_c <= RESET_C;
      st_ff.pg_state <= PG_OFF;
      st_ff.pout <= '{supply_on_output_n: 1'b1, wake_button_out_n: 1'b1,
        wake_event_out_n: 1'b1, power_good_out: 1'b0,
        kbc_sleep_state: 1'b1, bus_reset_out_n: 1'b0,
        flash_reset_out: 1'b0, pme_out_n: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  a_status_one_set: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    events.one[6] |=> st_ff.status_one[6])
    else $error("Watchdog event was not latched.");

  a_serial_set: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    events.serial[5] |=> st_ff.status_serial[5])
    else $error("Sixth serial port event was not latched.");

  a_w1c_clears: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    wr_fire && st_ff.aw_idx == IDX_STATUS_ONE && wr_ones[0] &&
    !events.one[0] |=> !st_ff.status_one[0])
    else $error("Write of one did not clear the status bit.");

  a_status_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    st_ff.status_serial[0] && !(wr_fire &&
    st_ff.aw_idx == IDX_STATUS_SERIAL) |=> st_ff.status_serial[0])
    else $error("Status bit dropped without a clearing write.");

  a_pme_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    (st_ff.enable_one == 7'h00 && st_ff.enable_serial == 6'h00) [*2]
    |-> st_ff.pout.pme_out_n)
    else $error("Event output asserted with every source disabled.");

  a_sleep_forced: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    st_ff.ctrl_a[A_SLEEP_TEST] |=> st_ff.pout.kbc_sleep_state)
    else $error("Sleep test bit did not force sleep state.");

  a_wake_gate: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    !st_ff.ctrl_a[A_KBD_WAKE] && !st_ff.ctrl_a[A_MOUSE_WAKE]
    |=> st_ff.pout.wake_event_out_n)
    else $error("Wake pin driven while both wake enables are off.");

  a_soft_clear: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    soft_now |=> !soft_now && st_ff.pg_state == PG_OFF)
    else $error("Soft reset did not complete and clear itself.");

  a_pg_drop: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    !main_ok |-> ##1 !st_ff.pout.power_good_out ##1
    !st_ff.pout.power_good_out)
    else $error("Power good held without main supply.");

  a_supply_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    !st_ff.ctrl_c[C_ON_DELAY_EN] && !st_ff.bypass_on && !soft_now
    |=> st_ff.supply_on == $past(sleep_awake))
    else $error("Supply on did not follow the sleep input.");

endmodule

/* tb/pmeac_supply_model.sv */
// Power supply and chipset model facing the sequencer pins.
`timescale 1ns/1ps
module pmeac_supply_model
  import pmeac_pkg::*;
#(
  parameter int RAMP = 60
) (
  input wire logic aclk,
  input wire logic mains,
  input wire logic sleep_n,
  input wire logic kbd,
  input wire logic mouse,
  input wire pmeac_pkg::pmeac_power_s power_out,
  output pmeac_pkg::pmeac_pins_s pins_in
);
  int ramp_ff;

  // The rails need RAMP cycles to come up after turn-on, but they drop at
  // once when the supply is switched off or mains goes away.
  always_ff @(posedge aclk) begin
    if (power_out.supply_on_output_n || !mains) begin
      ramp_ff <= 0;
    end else if (ramp_ff < RAMP) begin
      ramp_ff <= ramp_ff + 1;
    end
  end

  // The chipset holds bus reset until the rails are good.
  always_comb begin
    pins_in.main_supply_valid = (ramp_ff == RAMP);
    pins_in.bus_reset_in_n = (ramp_ff == RAMP);
    pins_in.supply_power_good_in = (ramp_ff == RAMP);
    pins_in.sleep_state_in_n = sleep_n;
    pins_in.keyboard_wake_in = kbd;
    pins_in.mouse_wake_in = mouse;
    pins_in.power_restore_in = mains;
  end
endmodule

/* tb/test_pme_status_acpi_power_control.sv */
// Self-checking bench for the event latch and power sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_pme_status_acpi_power_control;
  import pmeac_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic [31:0] rdata;
  logic awvalid = 0, wvalid = 0, arvalid = 0, awready, wready, arready;
  logic bvalid, rvalid, irq, flash_to = 0, mains = 0, slp_n = 0, kbd = 0;
  logic bready = 0, rready = 0, mouse = 0;
  logic [1:0] bresp, rresp, r;
  logic [7:0] d;
  pmeac_events_s ev = '0;
  pmeac_pins_s pins;
  pmeac_power_s pw;
  int errors = 0, n_tests = 0, n;

  pmeac_top #(.STEP_CYCLES(20), .OFF_HOLD_CYCLES(50)) i_pmeac_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(ev), .flash_timeout(flash_to), .pins_in(pins), .power_out(pw),
    .irq(irq));

  pmeac_supply_model i_pmeac_supply_model (
    .aclk(aclk), .mains(mains), .sleep_n(slp_n), .kbd(kbd), .mouse(mouse),
    .power_out(pw), .pins_in(pins));

  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;

  task automatic results;
    $display("Checks %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A wait that ran out of its bound ends the run as a failure.
  task automatic hung(input logic bad);
    if (bad) begin
      errors++;
      results();
    end
  endtask

  // Ready and response are sampled at the edge, before that edge's updates.
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    int k;
    logic a, w;
    a = 1;
    w = 1;
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    for (k = 0; k < 50 && (a || w); k++) begin
      @(posedge aclk);
      if (a && awready) begin
        a = 0;
        awvalid <= 0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    hung(a || w);
    bready <= 1;
    for (k = 0; k < 50 && !bvalid; k++) @(posedge aclk);
    hung(!bvalid);
    bready <= 0;
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] i);
    int k;
    logic a;
    a = 1;
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1;
    for (k = 0; k < 50 && a; k++) begin
      @(posedge aclk);
      a = !arready;
    end
    hung(a);
    arvalid <= 0;
    rready <= 1;
    for (k = 0; k < 50 && !rvalid; k++) @(posedge aclk);
    hung(!rvalid);
    rready <= 0;
    d = rdata[7:0];
    r = rresp;
  endtask

  task automatic rc(input string nm, input logic [7:0] i, input logic [7:0] e);
    rd(i);
    `CHK(nm, e, d)
  endtask

  // Main sequence: registers, event latches, then power sequencing.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc("ctrl_a", IDX_CONTROL_A, 8'h07);
    rc("ctrl_b", IDX_CONTROL_B, 8'h1C);
    rc("ctrl_c", IDX_CONTROL_C, 8'h00);
    wr(IDX_CONTROL_A, 8'h07);
    rc("loss", IDX_CONTROL_A, 8'h06);
    wr(IDX_CONTROL_B, 8'h9C);
    rc("soft_rst", IDX_CONTROL_B, 8'h1C);
    wr(8'h10, 8'h55);
    `CHK("bresp", RESP_DECERR, r)
    rc("unmapped", 8'h10, 8'h00);
    `CHK("rresp", RESP_DECERR, r)
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_ENABLE_SERIAL, 8'h20);
    // Events pile up one by one, so a bit in the wrong place shows at once.
    for (int i = 0; i < 13; i++) begin
      ev <= pmeac_events_s'(13'h1 << i);
      @(posedge aclk);
      ev <= '0;
      repeat (2) @(posedge aclk);
      if (i < 6) begin
        rc("serial", IDX_STATUS_SERIAL, 8'((1 << (i + 1)) - 1));
      end else begin
        rc("unit", IDX_STATUS_ONE, 8'((1 << (i - 5)) - 1));
      end
      `CHK("pme", 1'(i < 5), pw.pme_out_n)
    end
    wr(IDX_STATUS_SERIAL, 8'h00);
    rc("keep", IDX_STATUS_SERIAL, 8'h3F);
    wr(IDX_STATUS_SERIAL, 8'h20);
    rc("w1c", IDX_STATUS_SERIAL, 8'h1F);
    `CHK("pme_off", 1'b1, pw.pme_out_n)
    `CHK("irq", 1'b1, irq)
    rc("irq_st", IDX_IRQ_STATUS, 8'h01);
    @(posedge aclk);
    `CHK("irq_clr", 1'b0, irq)
    wr(IDX_STATUS_ONE, 8'hFF);
    rc("rsvd", IDX_STATUS_ONE, 8'h00);
    kbd <= 1;
    repeat (6) @(posedge aclk);
    `CHK("kbd_off", 1'b1, pw.wake_event_out_n)
    wr(IDX_CONTROL_A, 8'h16);
    repeat (6) @(posedge aclk);
    `CHK("kbd_on", 1'b0, pw.wake_event_out_n)
    kbd <= 0;
    mouse <= 1;
    repeat (6) @(posedge aclk);
    `CHK("mo_off", 1'b1, pw.wake_event_out_n)
    wr(IDX_CONTROL_A, 8'h0E);
    repeat (6) @(posedge aclk);
    `CHK("mo_on", 1'b0, pw.wake_event_out_n)
    mouse <= 0;
    mains <= 1;
    repeat (8) @(posedge aclk);
    `CHK("pol_off", 1'b1, pw.wake_button_out_n)
    mains <= 0;
    wr(IDX_CONTROL_A, 8'h04);
    mains <= 1;
    repeat (8) @(posedge aclk);
    `CHK("pol_on", 1'b0, pw.wake_button_out_n)
    slp_n <= 1;
    repeat (6) @(posedge aclk);
    `CHK("son", 1'b0, pw.supply_on_output_n)
    `CHK("kbc_vdd", 1'b1, pw.kbc_sleep_state)
    wr(IDX_CONTROL_C, 8'h80);
    repeat (3) @(posedge aclk);
    `CHK("kbc_sel", 1'b0, pw.kbc_sleep_state)
    wr(IDX_CONTROL_A, 8'h84);
    repeat (3) @(posedge aclk);
    `CHK("kbc_test", 1'b1, pw.kbc_sleep_state)
    wr(IDX_CONTROL_C, 8'h00);
    // With de-bounce on, the 1000-cycle window adds to the 4-step delay.
    for (n = 0; n < 200 && !pins.supply_power_good_in; n++) @(posedge aclk);
    hung(!pins.supply_power_good_in);
    for (n = 0; n < 1500 && !pw.power_good_out; n++) @(posedge aclk);
    `CHK("pg_db", 1'b1, 1'(n >= 1078 && n <= 1100))
    `CHK("brst", 1'b1, pw.bus_reset_out_n)
    flash_to <= 1;
    repeat (3) @(posedge aclk);
    `CHK("fl_off", 1'b0, pw.flash_reset_out)
    wr(IDX_CONTROL_A, 8'hC4);
    repeat (2) @(posedge aclk);
    `CHK("fl_on", 1'b1, pw.flash_reset_out)
    flash_to <= 0;
    wr(IDX_CONTROL_C, 8'h02);
    wr(IDX_CONTROL_B, 8'h7C);
    slp_n <= 0;
    repeat (20) @(posedge aclk);
    `CHK("pg_fall", 1'b0, pw.power_good_out)
    slp_n <= 1;
    for (n = 0; n < 200 && !pins.supply_power_good_in; n++) @(posedge aclk);
    hung(!pins.supply_power_good_in);
    for (n = 0; n < 400 && !pw.power_good_out; n++) @(posedge aclk);
    `CHK("pg_bypass", 1'b1, 1'(n >= 158 && n <= 172))
    wr(IDX_CONTROL_C, 8'h12);
    slp_n <= 0;
    repeat (5) @(posedge aclk);
    slp_n <= 1;
    for (n = 0; n < 200 && pw.supply_on_output_n; n++) @(posedge aclk);
    `CHK("on_hold", 1'b1, 1'(n >= 40 && n <= 56))
    // Bypass turns the supply back on one cycle after the low sleep input drops it.
    wr(IDX_CONTROL_C, 8'h02);
    mains <= 0;
    wr(IDX_CONTROL_A, 8'h02);
    slp_n <= 0;
    mains <= 1;
    repeat (8) @(posedge aclk);
    `CHK("pol_byp", 1'b0, pw.supply_on_output_n)
    mains <= 0;
    wr(IDX_CONTROL_A, 8'h00);
    mains <= 1;
    repeat (8) @(posedge aclk);
    `CHK("pol_keep", 1'b0, pw.wake_button_out_n)
    results();
  end
endmodule
